// File: core/powerline_control_transmitter.sv
// Top of the powerline home-control transmitter: pin selection, entry list and repeats
// Overview of operation
// - Modulation pin chosen by index, forced output
// - Zero-crossing pin chosen by index, forced input unless it is also the modulation pin
// - House code 0..15 means letters A..P
// - Values 0..15 are unit keys, else commands
// - Missing repeat count means send twice
// - House plus key, then house plus command
// - Select on and select off codes
// - All off and all lamps on codes
// - Dim and brighten codes
// - Command values pass unaltered, toggle by XOR
// - Entries sent in order, repeats finished first
// - Each dim repeat moves one of nineteen levels
// - Carrier gated near line zero crossings
// - Align to zero crossing within fifty microseconds
// - Each repetition is one eleven-bit sequence
`timescale 1ns/1ps

module powerline_control_transmitter #(
    parameter int BURST_CYC = plc_pkg::BURST_CYC_DEF
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SRST,
    // Operation start
    input wire logic START,
    input wire logic [3:0] MOD_PIN_SEL,
    input wire logic [3:0] ZC_PIN_SEL,
    output logic BUSY,
    // Entry list
    input wire logic ENTRY_VALID,
    output logic ENTRY_READY,
    input wire logic [3:0] ENTRY_HOUSE,
    input wire logic [4:0] KEY_OR_COMMAND_A,
    input wire logic [7:0] ENTRY_COUNT,
    input wire logic ENTRY_COUNT_GIVEN,
    input wire logic ENTRY_LAST,
    output logic CMD_UNKNOWN,
    // General I/O pins
    input wire logic [15:0] PIN_IN,
    output logic [15:0] PIN_OUT,
    output logic [15:0] PIN_OE
);
    typedef enum logic [1:0] {M_IDLE, M_FETCH, M_SEND, M_WAIT} mstate_t;

    typedef struct packed {
        mstate_t st;
        logic busy;
        logic ready;
        logic unknown;
        logic [3:0] mod_sel;
        logic [3:0] zc_sel;
        logic [3:0] house;
        logic [4:0] keycmd;
        logic [7:0] reps;
        logic last;
        logic [15:0] sync1;
        logic [15:0] sync2;
        logic zc_prev;
        logic [15:0] pin_out;
        logic [15:0] pin_oe;
    } mreg_t;

    mreg_t s_ff, nxt_s;

    logic mod_bit;
    logic frame_done;
    logic frame_active;
    logic zc_edge;
    logic frame_go;
    logic accept;

    // A value with the top bit set is a command; only the six listed are known
    function automatic logic cmd_is_known(input logic [4:0] v);
        cmd_is_known = !v[plc_pkg::CMD_FLAG_BIT] ||
            (v == plc_pkg::CMD_SELECT_ON) || (v == plc_pkg::CMD_SELECT_OFF) ||
            (v == plc_pkg::CMD_ALL_OFF) || (v == plc_pkg::CMD_ALL_LAMPS_ON) ||
            (v == plc_pkg::CMD_DIM) || (v == plc_pkg::CMD_BRIGHT);
    endfunction : cmd_is_known

    // Either edge of the synchronised zero-crossing pin marks a crossing
    assign zc_edge = s_ff.busy && (s_ff.sync2[s_ff.zc_sel] != s_ff.zc_prev);
    assign frame_go = (s_ff.st == M_SEND);
    assign accept = (s_ff.st == M_FETCH) && s_ff.ready && ENTRY_VALID;

    // ========================================================================
    // Frame sender
    plc_frame_sender #(
        .BURST_CYC(BURST_CYC)
    ) u_sender (
        .clk(CLK_SYS),
        .srst(SRST),
        .frame_go(frame_go),
        .zc_edge(zc_edge),
        .house(s_ff.house),
        .keycmd(s_ff.keycmd),
        .mod_out(mod_bit),
        .frame_done(frame_done),
        .active(frame_active)
    );

    // ========================================================================
    // Sequencer next state
    always_comb begin
        nxt_s = s_ff;
        nxt_s.unknown = 1'b0;
        // Two-stage synchroniser on all pins; only stage two is looked at
        nxt_s.sync1 = PIN_IN;
        nxt_s.sync2 = s_ff.sync1;
        nxt_s.zc_prev = s_ff.sync2[s_ff.zc_sel];
        unique case (s_ff.st)
            M_IDLE: begin
                // Starts while busy cannot reach here, so selections stay stable
                if (START) begin
                    nxt_s.busy = 1'b1;
                    nxt_s.ready = 1'b1;
                    nxt_s.st = M_FETCH;
                    nxt_s.mod_sel = MOD_PIN_SEL;
                    nxt_s.zc_sel = ZC_PIN_SEL;
                    nxt_s.zc_prev = s_ff.sync2[ZC_PIN_SEL];
                    nxt_s.pin_oe[ZC_PIN_SEL] = 1'b0;
                    nxt_s.pin_oe[MOD_PIN_SEL] = 1'b1;
                end
            end
            M_FETCH: begin
                if (accept) begin
                    nxt_s.ready = 1'b0;
                    // House and key or command travel untouched into the frame
                    nxt_s.house = ENTRY_HOUSE;
                    nxt_s.keycmd = KEY_OR_COMMAND_A;
                    nxt_s.unknown = !cmd_is_known(KEY_OR_COMMAND_A);
                    nxt_s.reps = ENTRY_COUNT_GIVEN ? ENTRY_COUNT : plc_pkg::DEFAULT_REPS;
                    nxt_s.last = ENTRY_LAST;
                    if (ENTRY_COUNT_GIVEN && (ENTRY_COUNT == '0)) begin
                        // A zero count sends nothing for this entry
                        nxt_s.st = ENTRY_LAST ? M_IDLE : M_FETCH;
                        nxt_s.busy = !ENTRY_LAST;
                        nxt_s.ready = !ENTRY_LAST;
                    end else begin
                        nxt_s.st = M_SEND;
                    end
                end
            end
            M_SEND: begin
                nxt_s.st = M_WAIT;
            end
            M_WAIT: begin
                // Every repeat is a full frame, so a dim entry steps one level each
                if (frame_done) begin
                    nxt_s.reps = s_ff.reps - 8'h01;
                    if (s_ff.reps != 8'h01) begin
                        nxt_s.st = M_SEND;
                    end else if (s_ff.last) begin
                        nxt_s.st = M_IDLE;
                        nxt_s.busy = 1'b0;
                    end else begin
                        // Next entry only after all repeats, which keeps key before command
                        nxt_s.st = M_FETCH;
                        nxt_s.ready = 1'b1;
                    end
                end
            end
        endcase
        // Pins other than the modulation pin are never driven high
        nxt_s.pin_out = '0;
        nxt_s.pin_out[s_ff.mod_sel] = s_ff.busy && frame_active && mod_bit;
    end

    // State register
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign BUSY = s_ff.busy;
    assign ENTRY_READY = s_ff.ready;
    assign CMD_UNKNOWN = s_ff.unknown;
    assign PIN_OUT = s_ff.pin_out;
    assign PIN_OE = s_ff.pin_oe;

    // ========================================================================
    // Checks
    mod_pin_out_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        s_ff.busy |-> PIN_OE[s_ff.mod_sel])
        else $error("modulation pin not driven");

    zc_pin_in_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        s_ff.busy && (s_ff.mod_sel != s_ff.zc_sel) |-> !PIN_OE[s_ff.zc_sel])
        else $error("zero-crossing pin driven");

    default_reps_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        accept && !ENTRY_COUNT_GIVEN |=> s_ff.reps == plc_pkg::DEFAULT_REPS)
        else $error("default repeat count not two");

    keycmd_pass_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        accept |=> s_ff.keycmd == $past(KEY_OR_COMMAND_A) && s_ff.house == $past(ENTRY_HOUSE))
        else $error("entry code altered");

    busy_hold_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        s_ff.busy && START |=> $stable(s_ff.mod_sel) && $stable(s_ff.zc_sel))
        else $error("start taken while busy");

    repeat_next_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (s_ff.st == M_WAIT) && frame_done && (s_ff.reps != 8'h01) |=> (s_ff.st == M_SEND) && !s_ff.ready)
        else $error("entry advanced before repeats done");

    quiet_idle_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        !s_ff.busy && !$past(s_ff.busy) |-> PIN_OUT == '0)
        else $error("pin driven high while idle");
endmodule : powerline_control_transmitter

// File: core/plc_frame_sender.sv
// Shared constants and the zero-crossing frame sender for the powerline transmitter
// ============================================================================
// Constants
package plc_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int CARRIER_HZ = 120_000;
    // Longest half period, rounded down
    localparam int CAR_HALF_CYC = CLK_HZ / (2 * CARRIER_HZ);
    localparam int ALIGN_US = 50;
    localparam int ALIGN_CYC = (CLK_HZ / 1_000_000) * ALIGN_US;
    localparam int BURST_US = 1000;
    localparam int BURST_CYC_DEF = (CLK_HZ / 1_000_000) * BURST_US;
    localparam int LEVEL_COUNT = 19;
    localparam logic [7:0] DEFAULT_REPS = 8'h02;
    localparam logic [4:0] CMD_SELECT_ON = 5'h12;
    localparam logic [4:0] CMD_SELECT_OFF = 5'h1a;
    localparam logic [4:0] CMD_ALL_OFF = 5'h1c;
    localparam logic [4:0] CMD_ALL_LAMPS_ON = 5'h14;
    localparam logic [4:0] CMD_DIM = 5'h1e;
    localparam logic [4:0] CMD_BRIGHT = 5'h16;
    localparam logic [4:0] TOGGLE_MASK = 5'h08;
    localparam int CMD_FLAG_BIT = 4;
    localparam logic [3:0] START_PATTERN = 4'he;
    localparam logic [4:0] START_SLOTS = 5'h04;
    localparam logic [4:0] DATA_END_SLOT = 5'h16;
    localparam logic [4:0] LAST_SLOT = 5'h1b;
    localparam int DATA_BITS = 9;
    localparam logic [4:0] SLOT_ZERO = 5'h00;
    localparam logic [4:0] SLOT_ONE = 5'h01;
endpackage : plc_pkg

`timescale 1ns/1ps

// ============================================================================
// Frame sender: one code sequence, one slot per zero crossing
module plc_frame_sender #(
    parameter int BURST_CYC = plc_pkg::BURST_CYC_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Frame request
    input wire logic frame_go,
    input wire logic [3:0] house,
    input wire logic [4:0] keycmd,
    // Line timing
    input wire logic zc_edge,
    // Results
    output logic mod_out,
    output logic frame_done,
    output logic active
);
    typedef enum logic {L_IDLE, L_RUN} lstate_t;

    typedef struct packed {
        lstate_t st;
        logic [4:0] slot;
        logic [15:0] burst_cnt;
        logic [7:0] car_cnt;
        logic car;
        logic prev_bit;
        logic [8:0] data;
        logic mod;
        logic done;
    } lreg_t;

    lreg_t s_ff, nxt_s;

    // Slot pattern: start code, then each data bit true then complemented, then silence
    function automatic logic slot_bit(input logic [4:0] slot, input logic [8:0] data);
        logic [4:0] rel;
        logic [3:0] idx;
        rel = '0;
        idx = '0;
        slot_bit = 1'b0;
        if (slot < plc_pkg::START_SLOTS) begin
            slot_bit = plc_pkg::START_PATTERN[2'(3 - int'(slot))];
        end else if (slot < plc_pkg::DATA_END_SLOT) begin
            rel = slot - plc_pkg::START_SLOTS;
            idx = 4'(plc_pkg::DATA_BITS - 1) - 4'(rel[4:1]);
            slot_bit = data[idx] ^ rel[0];
        end
    endfunction : slot_bit

    logic cur_bit;
    assign cur_bit = slot_bit(s_ff.slot, s_ff.data);

    // Next state
    always_comb begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        // Carrier runs only while a burst is counting down
        if (s_ff.burst_cnt != '0) begin
            nxt_s.burst_cnt = s_ff.burst_cnt - 16'h0001;
            if (s_ff.car_cnt == 8'(plc_pkg::CAR_HALF_CYC - 1)) begin
                nxt_s.car_cnt = '0;
                nxt_s.car = ~s_ff.car;
            end else begin
                nxt_s.car_cnt = s_ff.car_cnt + 8'h01;
            end
        end
        unique case (s_ff.st)
            L_IDLE: begin
                nxt_s.burst_cnt = '0;
                if (frame_go) begin
                    nxt_s.st = L_RUN;
                    nxt_s.slot = '0;
                    nxt_s.data = {house, keycmd};
                end
            end
            L_RUN: begin
                // Burst starts on the edge itself, far inside the alignment window
                if (zc_edge) begin
                    if (cur_bit) begin
                        nxt_s.burst_cnt = 16'(BURST_CYC);
                        nxt_s.car_cnt = '0;
                        nxt_s.car = 1'b1;
                    end
                    nxt_s.prev_bit = cur_bit;
                    if (s_ff.slot == plc_pkg::LAST_SLOT) begin
                        nxt_s.st = L_IDLE;
                        nxt_s.done = 1'b1;
                    end else begin
                        nxt_s.slot = s_ff.slot + plc_pkg::SLOT_ONE;
                    end
                end
            end
        endcase
        nxt_s.mod = (nxt_s.burst_cnt != '0) && (nxt_s.st == L_RUN) && nxt_s.car;
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign mod_out = s_ff.mod;
    assign frame_done = s_ff.done;
    assign active = (s_ff.st == L_RUN);

    // Carrier appears the cycle after a marked edge
    burst_align_a: assert property (@(posedge clk) disable iff (srst)
        (s_ff.st == L_RUN) && zc_edge && cur_bit |=> s_ff.mod)
        else $error("burst did not start on zero crossing");

    // Unmarked slots stay silent
    silent_slot_a: assert property (@(posedge clk) disable iff (srst)
        (s_ff.st == L_RUN) && zc_edge && !cur_bit && (s_ff.burst_cnt == '0) |=> !s_ff.mod)
        else $error("carrier in unmarked slot");

    // Each data bit is followed by its complement
    complement_bit_a: assert property (@(posedge clk) disable iff (srst)
        (s_ff.st == L_RUN) && zc_edge && (s_ff.slot > plc_pkg::START_SLOTS) &&
        (s_ff.slot < plc_pkg::DATA_END_SLOT) && s_ff.slot[0] |-> cur_bit != s_ff.prev_bit)
        else $error("data bit not complemented");

    // Frame ends only after the last slot
    frame_length_a: assert property (@(posedge clk) disable iff (srst)
        $rose(s_ff.done) |-> $past(s_ff.slot) == plc_pkg::LAST_SLOT)
        else $error("frame ended early");

    // No carrier while idle
    idle_silent_a: assert property (@(posedge clk) disable iff (srst)
        (s_ff.st == L_IDLE) && $past(s_ff.st == L_IDLE) |-> !s_ff.mod)
        else $error("carrier while idle");
endmodule : plc_frame_sender

// File: testbench/plc_line_model.sv
// Behavioural powerline interface: free-running zero crossings and a slot decoder on the modulation line
`timescale 1ns/1ps

// ============================================================================
// Line interface model
module plc_line_model #(
    parameter int HALF_CYC = 80
) (
    // Clock
    input wire logic clk,
    // Pins toward the transmitter
    input wire logic mod_line,
    output logic zc_line
);
    int phase;
    int slot_n;
    int bad_frames;
    logic seen;
    logic [21:0] slots;
    logic [8:0] frame_q[$];

    // Start with the line low and the decoder empty
    initial begin
        zc_line = 1'b0;
        phase = 0;
        slot_n = 0;
        bad_frames = 0;
        seen = 1'b0;
        slots = '0;
    end

    // Check start pattern and bit/complement pairs, then queue the house and code
    task automatic check_frame();
        logic [8:0] word;
        word = '0;
        if (slots[21:18] !== 4'he) begin
            bad_frames++;
        end
        for (int i = 0; i < 9; i++) begin
            word = {word[7:0], slots[17 - 2 * i]};
            if (slots[16 - 2 * i] === slots[17 - 2 * i]) begin
                bad_frames++;
            end
        end
        frame_q.push_back(word);
    endtask : check_frame

    // Mains crossings run free; any carrier within a half period marks that slot as a one
    always @(posedge clk) begin
        if (mod_line === 1'b1) begin
            seen = 1'b1;
        end
        if (phase == HALF_CYC - 1) begin
            phase = 0;
            zc_line <= ~zc_line;
            // A frame begins with a marked slot; silent gaps are skipped
            if (slot_n > 0 || seen) begin
                slots = {slots[20:0], seen};
                slot_n++;
            end
            seen = 1'b0;
            if (slot_n == 22) begin
                check_frame();
                slot_n = 0;
            end
        end else begin
            phase++;
        end
    end
endmodule : plc_line_model

// File: testbench/powerline_control_transmitter_bench.sv
// Self-checking bench for the powerline transmitter
`timescale 1ns/1ps

// ============================================================================
// Bench top
module powerline_control_transmitter_bench;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic start = 1'b0;
    logic e_valid = 1'b0;
    logic e_given = 1'b0;
    logic e_last = 1'b0;
    logic [3:0] mod_drv = 4'h0;
    logic [3:0] zc_drv = 4'h0;
    logic [3:0] mod_sel = 4'h0;
    logic [3:0] zc_sel = 4'h0;
    logic [3:0] e_house = 4'h0;
    logic [4:0] e_code = 5'h00;
    logic [7:0] e_count = 8'h00;
    logic busy, ready, unk, zc_line;
    logic [15:0] pin_in, pin_out, pin_oe;
    logic [8:0] exp_q[$];
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;

    always #12.5 clk_sys = ~clk_sys;
    // Unused pins float to the pull-up level
    assign pin_in = zc_line ? 16'hffff : ~(16'h0001 << zc_sel);

    powerline_control_transmitter #(.BURST_CYC(40)) i_dut (
        .CLK_SYS(clk_sys), .SRST(srst), .START(start), .MOD_PIN_SEL(mod_drv), .ZC_PIN_SEL(zc_drv),
        .BUSY(busy), .ENTRY_VALID(e_valid), .ENTRY_READY(ready), .ENTRY_HOUSE(e_house),
        .KEY_OR_COMMAND_A(e_code), .ENTRY_COUNT(e_count), .ENTRY_COUNT_GIVEN(e_given),
        .ENTRY_LAST(e_last), .CMD_UNKNOWN(unk), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe));

    plc_line_model #(.HALF_CYC(80)) i_line (.clk(clk_sys), .mod_line(pin_out[mod_sel]), .zc_line(zc_line));

    // ========================================================================
    // Shared tasks
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        if (errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // Hang guard, well above the 25 frames the scenarios need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            complete_run();
        end
    end

    // Carrier only on the chosen pin, and none while idle
    always @(negedge clk_sys) begin
        if (!srst && (pin_out & (busy === 1'b1 ? ~(16'h0001 << mod_sel) : 16'hffff)) !== 16'h0000) begin
            check("stray_carrier", pin_out, 16'h0000);
        end
    end

    task automatic run_start(input logic [3:0] m, input logic [3:0] z);
        @(posedge clk_sys);
        start <= 1'b1;
        mod_drv <= m;
        zc_drv <= z;
        // Non-blocking, so the pin levels never race the sampling edge
        mod_sel <= m;
        zc_sel <= z;
        @(posedge clk_sys);
        start <= 1'b0;
        @(negedge clk_sys);
        check("busy", busy, 16'h0001);
        check("ready", ready, 16'h0001);
        check("mod_oe", pin_oe[m], 16'h0001);
        check("zc_oe", pin_oe[z], 16'h0000);
    endtask : run_start

    // Wait for ready, offer one entry for a single cycle, then judge the unknown-code flag
    task automatic send_entry(input logic [3:0] h, input logic [4:0] c, input logic [7:0] n,
                              input logic g, input logic l, input logic u);
        int k;
        k = 0;
        while (ready !== 1'b1 && k < 20000) begin
            @(negedge clk_sys);
            k++;
        end
        @(posedge clk_sys);
        e_valid <= 1'b1;
        e_house <= h;
        e_code <= c;
        e_count <= n;
        e_given <= g;
        e_last <= l;
        @(posedge clk_sys);
        e_valid <= 1'b0;
        @(negedge clk_sys);
        check("cmd_unknown", unk, {15'h0000, u});
        for (int i = 0; i < (g ? int'(n) : 2); i++) begin
            exp_q.push_back({h, c});
        end
    endtask : send_entry

    // Wait for the operation to end, then compare decoded frames in order
    task automatic finish_op();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 40000) begin
            @(negedge clk_sys);
            k++;
        end
        check("busy_end", busy, 16'h0000);
        check("bad_frames", 16'(i_line.bad_frames), 16'h0000);
        check("frame_count", 16'(i_line.frame_q.size()), 16'(exp_q.size()));
        while (exp_q.size() > 0 && i_line.frame_q.size() > 0) begin
            check("frame", {7'h00, i_line.frame_q.pop_front()}, {7'h00, exp_q.pop_front()});
        end
        exp_q.delete();
        i_line.frame_q.delete();
    endtask : finish_op

    // ========================================================================
    // Scenarios
    task automatic test_select_on();
        run_start(4'h5, 4'h9);
        check("oe_first", pin_oe, 16'h0020);
        // Key entry carries an explicit two inside a list
        send_entry(4'h3, 5'h00, 8'h02, 1'b1, 1'b0, 1'b0);
        send_entry(4'h3, plc_pkg::CMD_SELECT_ON, 8'h00, 1'b0, 1'b1, 1'b0);
        finish_op();
    endtask : test_select_on

    task automatic test_codes();
        logic [4:0] snd [8];
        logic [4:0] lit [8];
        snd = '{plc_pkg::CMD_SELECT_ON, plc_pkg::CMD_SELECT_OFF, plc_pkg::CMD_ALL_OFF, plc_pkg::CMD_ALL_LAMPS_ON,
                plc_pkg::CMD_DIM, plc_pkg::CMD_BRIGHT, plc_pkg::CMD_SELECT_ON ^ plc_pkg::TOGGLE_MASK, 5'h10};
        lit = '{5'h12, 5'h1a, 5'h1c, 5'h14, 5'h1e, 5'h16, 5'h1a, 5'h10};
        run_start(4'h0, 4'hf);
        for (int i = 0; i < 8; i++) begin
            check("code_value", {11'h000, snd[i]}, {11'h000, lit[i]});
            // Inside a list every entry carries an explicit two
            send_entry(4'(2 * i), snd[i], 8'h02, 1'b1, i == 7, i == 7);
        end
        finish_op();
    endtask : test_codes

    task automatic test_dim_skip();
        run_start(4'hf, 4'h0);
        send_entry(4'hf, 5'h0f, 8'h02, 1'b1, 1'b0, 1'b0);
        // A refused start must leave the enables alone
        @(posedge clk_sys);
        start <= 1'b1;
        mod_drv <= 4'h3;
        @(posedge clk_sys);
        start <= 1'b0;
        @(negedge clk_sys);
        check("oe_refused", pin_oe[3], 16'h0000);
        send_entry(4'hf, plc_pkg::CMD_SELECT_OFF, 8'h00, 1'b1, 1'b0, 1'b0);
        send_entry(4'hf, plc_pkg::CMD_DIM, 8'h03, 1'b1, 1'b1, 1'b0);
        finish_op();
    endtask : test_dim_skip

    // ========================================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        @(negedge clk_sys);
        check("rst_busy", busy, 16'h0000);
        check("rst_ready", ready, 16'h0000);
        check("rst_out", pin_out, 16'h0000);
        check("rst_oe", pin_oe, 16'h0000);
        test_select_on();
        test_codes();
        test_dim_skip();
        complete_run();
    end
endmodule : powerline_control_transmitter_bench
